// ---- shared/sgu_pkg.sv ----
// Constants, register map and field layout of the system glue unit.
// Function
// - Control bits 15 to 6 read zero and ignore writes.
// - Control bit 5 keeps debug clock on; else only while test port enabled.
// - Control bit 4 reads zero; writing one starts a chip reset.
// - Stop field 00: stop instruction enters Stop mode.
// - Stop field 01: stop instruction refused, field stays writable.
// - Stop field 10 or 11: stop refused, field locked until reset.
// - Wait field 00: wait instruction enters Wait mode.
// - Wait field 01: wait instruction refused, field stays writable.
// - Wait field 10 or 11: wait refused, field locked until reset.
// - Reset-cause flags initialised by power-on only; other resets only set.
// - Soft reset flag reads one after a software-triggered reset.
// - Watchdog flag reads one after watchdog reset; cleared by power-on or software.
// - Pin flag reads one after pin reset; cleared by power-on or software.
// - Power-on flag reads one after power-on; cleared by software.
// - Writing zero sets a reset-cause flag, writing one clears it.
// - Four scratch words reset only by power-on, kept across other resets.
package sgu_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    localparam int IDX_W = 6;

    // Register indices; the byte address is four times the index.
    localparam logic [IDX_W-1:0] IDX_CONTROL = 6'h00;
    localparam logic [IDX_W-1:0] IDX_RST_STATUS = 6'h01;
    localparam logic [IDX_W-1:0] IDX_SCRATCH_0 = 6'h02;
    localparam logic [IDX_W-1:0] IDX_SCRATCH_3 = 6'h05;
    localparam logic [IDX_W-1:0] IDX_ID_UPPER = 6'h06;
    localparam logic [IDX_W-1:0] IDX_ID_LOWER = 6'h07;
    localparam logic [IDX_W-1:0] IDX_RESERVED = 6'h09;
    localparam logic [IDX_W-1:0] IDX_LAST_MAP = 6'h0f;
    localparam logic [IDX_W-1:0] IDX_INT_STATUS = 6'h10;
    localparam logic [IDX_W-1:0] IDX_INT_MASK = 6'h11;

    // Control register fields.
    localparam int CTL_DBG_BIT = 5;
    localparam int CTL_SWRST_BIT = 4;
    localparam int CTL_STOP_LSB = 2;
    localparam int CTL_WAIT_LSB = 0;
    localparam logic [REG_W-1:0] CTL_RESET = 16'h0000;

    // Reset-cause flag positions.
    localparam int RS_SOFT_BIT = 5;
    localparam int RS_WDOG_BIT = 4;
    localparam int RS_PIN_BIT = 3;
    localparam int RS_POR_BIT = 2;
    localparam logic [REG_W-1:0] RS_MASK = 16'h003c;
    localparam logic [REG_W-1:0] RS_POR_VALUE = 16'h0004;

    // Identification halves; values are arbitrary.
    localparam logic [REG_W-1:0] ID_UPPER_VAL = 16'h1234;
    localparam logic [REG_W-1:0] ID_LOWER_VAL = 16'h5678;

    // Plain storage registers: index, writable bits, fixed bits, reset.
    localparam int GEN_N = 7;
    localparam logic [IDX_W-1:0] GEN_IDX [GEN_N] =
        '{6'h08, 6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h0f};
    localparam logic [REG_W-1:0] GEN_WMASK [GEN_N] =
        '{16'h7fa8, 16'h03ff, 16'h003f, 16'hffff, 16'h0003, 16'hffff,
          16'h0001};
    localparam logic [REG_W-1:0] GEN_FIXED [GEN_N] =
        '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hfffc, 16'h0000,
          16'h0000};
    localparam logic [REG_W-1:0] GEN_RESET [GEN_N] =
        '{16'h0000, 16'h0020, 16'h0000, 16'h0000, 16'h0003, 16'h0000,
          16'h0000};

    // Interrupt events.
    localparam int INT_W = 3;
    localparam int INT_STOP_BIT = 0;
    localparam int INT_WAIT_BIT = 1;
    localparam int INT_RST_BIT = 2;

    // Hold time of a chip reset issued by this unit.
    localparam int CLK_HZ = 20_000_000;
    localparam int RST_HOLD_NS = 4800;
    localparam int RST_HOLD_CYC = (RST_HOLD_NS * (CLK_HZ / 1_000_000)
        + 999) / 1000;
    localparam int HOLD_W = 8;
endpackage

// ---- hw/sgu_regs.sv ----
// System glue unit: control, reset-cause and scratch registers over APB.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ns
module sgu_regs (
    // Clock and power-on reset.
    input wire logic MCLK,
    input wire logic RSTN,
    // APB slave.
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [sgu_pkg::ADDR_W-1:0] PADDR,
    input wire logic [sgu_pkg::DATA_W-1:0] PWDATA,
    output logic [sgu_pkg::DATA_W-1:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Reset sources and chip reset request.
    input wire logic PIN_RESET_N,
    input wire logic WDOG_RESET,
    output logic SYS_RESET_N,
    // Core low-power and debug handshakes.
    input wire logic CORE_STOP_REQ,
    input wire logic CORE_WAIT_REQ,
    input wire logic CORE_TAP_EN,
    output logic STOP_ENTER,
    output logic WAIT_ENTER,
    output logic DEBUG_CLK_EN,
    // Interrupt.
    output logic IRQ
);
    localparam int REG_W = sgu_pkg::REG_W;
    localparam int GEN_N = sgu_pkg::GEN_N;
    localparam int INT_W = sgu_pkg::INT_W;
    localparam logic [sgu_pkg::HOLD_W-1:0] HOLD_LAST =
        sgu_pkg::HOLD_W'(sgu_pkg::RST_HOLD_CYC - 1);

    logic rst_meta_ff;
    logic rst_n_ff;
    logic pin_meta_ff;
    logic pin_n_ff;

    logic [REG_W-1:0] ctrl_ff;
    logic [REG_W-1:0] rsts_ff;
    logic [REG_W-1:0] scr_ff [4];
    logic [REG_W-1:0] gen_ff [GEN_N];
    logic [INT_W-1:0] int_sts_ff;
    logic [INT_W-1:0] int_mask_ff;

    logic hold_ff;
    logic [sgu_pkg::HOLD_W-1:0] hold_cnt_ff;
    logic [REG_W-1:0] nxt_rsts;
    logic [REG_W-1:0] rd_val;
    logic rd_ok;

    logic acc_phase;
    logic wr_stb;
    logic [sgu_pkg::IDX_W-1:0] idx;
    logic [REG_W-1:0] wdata;
    logic soft_req;
    logic pin_req;
    logic any_req;
    logic stop_block;
    logic wait_block;
    logic [INT_W-1:0] int_evt;

    // Power-on reset release through two flops.
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff <= rst_meta_ff;
        end
    end

    // External reset pin synchroniser.
    always_ff @(posedge MCLK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            pin_meta_ff <= 1'b1;
            pin_n_ff <= 1'b1;
        end else begin
            pin_meta_ff <= PIN_RESET_N;
            pin_n_ff <= pin_meta_ff;
        end
    end

    function automatic logic idx_mapped(input logic [sgu_pkg::IDX_W-1:0] i);
        idx_mapped = (i <= sgu_pkg::IDX_LAST_MAP)
            || (i == sgu_pkg::IDX_INT_STATUS)
            || (i == sgu_pkg::IDX_INT_MASK);
    endfunction

    assign idx = PADDR[sgu_pkg::ADDR_W-1:2];
    assign wdata = PWDATA[REG_W-1:0];
    assign acc_phase = PSEL && PENABLE;
    assign wr_stb = acc_phase && PREADY && PWRITE && !PSLVERR;

    // A one written to the trigger bit starts a chip reset.
    assign soft_req = wr_stb && (idx == sgu_pkg::IDX_CONTROL)
        && wdata[sgu_pkg::CTL_SWRST_BIT];
    assign pin_req = !pin_n_ff;
    assign any_req = soft_req || pin_req || WDOG_RESET;

    // Chip reset hold; a live pin keeps restarting the count.
    always_ff @(posedge MCLK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            hold_ff <= 1'b0;
            hold_cnt_ff <= '0;
        end else if (any_req) begin
            hold_ff <= 1'b1;
            hold_cnt_ff <= '0;
        end else if (hold_ff) begin
            if (hold_cnt_ff == HOLD_LAST) begin
                hold_ff <= 1'b0;
            end
            hold_cnt_ff <= hold_cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge MCLK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            SYS_RESET_N <= 1'b0;
        end else begin
            SYS_RESET_N <= !(hold_ff || any_req);
        end
    end

    // Control register, cleared by every kind of reset.
    always_ff @(posedge MCLK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            ctrl_ff <= sgu_pkg::CTL_RESET;
        end else if (hold_ff || any_req) begin
            ctrl_ff <= sgu_pkg::CTL_RESET;
        end else if (wr_stb && idx == sgu_pkg::IDX_CONTROL) begin
            ctrl_ff[sgu_pkg::CTL_DBG_BIT] <=
                wdata[sgu_pkg::CTL_DBG_BIT];
            if (!ctrl_ff[sgu_pkg::CTL_STOP_LSB+1]) begin
                ctrl_ff[sgu_pkg::CTL_STOP_LSB +: 2] <=
                    wdata[sgu_pkg::CTL_STOP_LSB +: 2];
            end
            if (!ctrl_ff[sgu_pkg::CTL_WAIT_LSB+1]) begin
                ctrl_ff[sgu_pkg::CTL_WAIT_LSB +: 2] <=
                    wdata[sgu_pkg::CTL_WAIT_LSB +: 2];
            end
        end
    end

    // Reset-cause flags: hardware set wins over a software clear.
    always_comb begin
        nxt_rsts = rsts_ff;
        if (wr_stb && idx == sgu_pkg::IDX_RST_STATUS) begin
            nxt_rsts = ~wdata;
        end
        if (soft_req) begin
            nxt_rsts[sgu_pkg::RS_SOFT_BIT] = 1'b1;
        end
        if (WDOG_RESET) begin
            nxt_rsts[sgu_pkg::RS_WDOG_BIT] = 1'b1;
        end
        if (pin_req) begin
            nxt_rsts[sgu_pkg::RS_PIN_BIT] = 1'b1;
        end
        nxt_rsts = nxt_rsts & sgu_pkg::RS_MASK;
    end

    always_ff @(posedge MCLK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            rsts_ff <= sgu_pkg::RS_POR_VALUE;
        end else begin
            rsts_ff <= nxt_rsts;
        end
    end

    // Scratch words: only the power-on reset touches them.
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_scr
            always_ff @(posedge MCLK or negedge rst_n_ff) begin
                if (!rst_n_ff) begin
                    scr_ff[g] <= '0;
                end else if (wr_stb && idx ==
                        sgu_pkg::IDX_SCRATCH_0 + sgu_pkg::IDX_W'(g)) begin
                    scr_ff[g] <= wdata;
                end
            end
        end
        for (g = 0; g < GEN_N; g++) begin : g_gen
            always_ff @(posedge MCLK or negedge rst_n_ff) begin
                if (!rst_n_ff) begin
                    gen_ff[g] <= sgu_pkg::GEN_RESET[g];
                end else if (hold_ff || any_req) begin
                    gen_ff[g] <= sgu_pkg::GEN_RESET[g];
                end else if (wr_stb && idx == sgu_pkg::GEN_IDX[g]) begin
                    gen_ff[g] <= (wdata & sgu_pkg::GEN_WMASK[g])
                        | sgu_pkg::GEN_FIXED[g];
                end
            end
        end
    endgenerate

    // Stop and wait gating; a disabled field refuses the instruction.
    assign stop_block = |ctrl_ff[sgu_pkg::CTL_STOP_LSB +: 2];
    assign wait_block = |ctrl_ff[sgu_pkg::CTL_WAIT_LSB +: 2];

    always_ff @(posedge MCLK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            STOP_ENTER <= 1'b0;
            WAIT_ENTER <= 1'b0;
            DEBUG_CLK_EN <= 1'b0;
        end else begin
            STOP_ENTER <= CORE_STOP_REQ && !stop_block;
            WAIT_ENTER <= CORE_WAIT_REQ && !wait_block;
            DEBUG_CLK_EN <= ctrl_ff[sgu_pkg::CTL_DBG_BIT]
                || CORE_TAP_EN;
        end
    end

    // Interrupt status: write one to clear, a new event wins.
    always_comb begin
        int_evt = '0;
        int_evt[sgu_pkg::INT_STOP_BIT] = CORE_STOP_REQ && stop_block;
        int_evt[sgu_pkg::INT_WAIT_BIT] = CORE_WAIT_REQ && wait_block;
        int_evt[sgu_pkg::INT_RST_BIT] = hold_ff && !any_req
            && hold_cnt_ff == HOLD_LAST;
    end

    always_ff @(posedge MCLK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            int_sts_ff <= '0;
        end else if (wr_stb && idx == sgu_pkg::IDX_INT_STATUS) begin
            int_sts_ff <= (int_sts_ff & ~wdata[INT_W-1:0]) | int_evt;
        end else begin
            int_sts_ff <= int_sts_ff | int_evt;
        end
    end

    always_ff @(posedge MCLK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            int_mask_ff <= '0;
        end else if (wr_stb && idx == sgu_pkg::IDX_INT_MASK) begin
            int_mask_ff <= wdata[INT_W-1:0];
        end
    end

    always_ff @(posedge MCLK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(int_sts_ff & int_mask_ff);
        end
    end

    // Read multiplexer.
    always_comb begin
        rd_val = '0;
        rd_ok = idx_mapped(idx) && (PADDR[1:0] == 2'b00);
        if (idx == sgu_pkg::IDX_CONTROL) begin
            // Trigger bit and the upper bits read as zero.
            rd_val = {10'h000, ctrl_ff[sgu_pkg::CTL_DBG_BIT], 1'b0,
                ctrl_ff[3:0]};
        end else if (idx == sgu_pkg::IDX_RST_STATUS) begin
            rd_val = rsts_ff;
        end else if (idx >= sgu_pkg::IDX_SCRATCH_0
                && idx <= sgu_pkg::IDX_SCRATCH_3) begin
            rd_val = scr_ff[2'(idx - sgu_pkg::IDX_SCRATCH_0)];
        end else if (idx == sgu_pkg::IDX_ID_UPPER) begin
            rd_val = sgu_pkg::ID_UPPER_VAL;
        end else if (idx == sgu_pkg::IDX_ID_LOWER) begin
            rd_val = sgu_pkg::ID_LOWER_VAL;
        end else if (idx == sgu_pkg::IDX_INT_STATUS) begin
            rd_val = {13'h0000, int_sts_ff};
        end else if (idx == sgu_pkg::IDX_INT_MASK) begin
            rd_val = {13'h0000, int_mask_ff};
        end else begin
            for (int i = 0; i < GEN_N; i++) begin
                if (idx == sgu_pkg::GEN_IDX[i]) begin
                    rd_val = gen_ff[i];
                end
            end
        end
    end

    // APB answer: one wait cycle, then PREADY for one cycle.
    always_ff @(posedge MCLK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= '0;
        end else if (acc_phase && !PREADY) begin
            PREADY <= 1'b1;
            PSLVERR <= !rd_ok;
            PRDATA <= (rd_ok && !PWRITE) ? {16'h0000, rd_val} : '0;
        end else begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end
    end
endmodule

// ---- test/sgu_core_model.sv ----
// Behavioural core that issues stop and wait instruction pulses.
`timescale 1ns/1ns
module sgu_core_model (
    // Clock and command.
    input wire logic clk,
    input wire logic go,
    // Low-power instruction pulses.
    output logic stop_req,
    output logic wait_req
);
    initial begin
        stop_req = 1'b0;
        wait_req = 1'b0;
    end
    // Each command drives both instructions one cycle later, for as long as go is held.
    always @(posedge clk) begin
        stop_req <= go;
        wait_req <= go;
    end
endmodule

// ---- test/sgu_regs_asserts.sv ----
// Concurrent checks on the ports of the system glue unit.
`timescale 1ns/1ns
module sgu_regs_asserts (
    // Clock and reset.
    input wire logic MCLK,
    input wire logic RSTN,
    // APB.
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [sgu_pkg::ADDR_W-1:0] PADDR,
    input wire logic [sgu_pkg::DATA_W-1:0] PWDATA,
    input wire logic [sgu_pkg::DATA_W-1:0] PRDATA,
    input wire logic PREADY,
    // Resets and core.
    input wire logic WDOG_RESET,
    input wire logic SYS_RESET_N,
    input wire logic CORE_STOP_REQ,
    input wire logic CORE_WAIT_REQ,
    input wire logic CORE_TAP_EN,
    input wire logic STOP_ENTER,
    input wire logic WAIT_ENTER,
    input wire logic DEBUG_CLK_EN
);
    logic [1:0] stop_ff;
    logic [1:0] wait_ff;
    logic dbg_ff;
    logic ctl_wr;
    logic rd_done;
    logic dbg_want;

    assign ctl_wr = PSEL && PENABLE && PREADY && PWRITE && PADDR == 8'h00;
    assign rd_done = PSEL && PENABLE && PREADY && !PWRITE;
    assign dbg_want = dbg_ff || CORE_TAP_EN;

    // Mirror of the control fields; a field with its upper bit set is locked.
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            stop_ff <= 2'h0;
            wait_ff <= 2'h0;
            dbg_ff <= 1'b0;
        end else if (!SYS_RESET_N) begin
            stop_ff <= 2'h0;
            wait_ff <= 2'h0;
            dbg_ff <= 1'b0;
        end else if (ctl_wr) begin
            stop_ff <= stop_ff[1] ? stop_ff : PWDATA[3:2];
            wait_ff <= wait_ff[1] ? wait_ff : PWDATA[1:0];
            dbg_ff <= PWDATA[5];
        end
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RSTN);

    sequence apb_setup;
        PSEL && !PENABLE;
    endsequence
    sequence apb_access;
        PSEL && PENABLE;
    endsequence

    apb_answer_a: assert property (apb_setup ##1 apb_access |=> PREADY)
        else $error("APB access not answered after one cycle");
    ctl_read_a: assert property (
        rd_done && PADDR == 8'h00 |-> PRDATA[31:6] == 0 && !PRDATA[4])
        else $error("control read shows reserved or trigger bits");
    id_read_a: assert property (
        rd_done && PADDR == 8'h18 |-> PRDATA[15:0] == sgu_pkg::ID_UPPER_VAL)
        else $error("identification word wrong");
    stop_gate_a: assert property (
        CORE_STOP_REQ && SYS_RESET_N |=> STOP_ENTER == (stop_ff == 2'h0))
        else $error("stop entry disagrees with stop field");
    wait_gate_a: assert property (
        CORE_WAIT_REQ && SYS_RESET_N |=> WAIT_ENTER == (wait_ff == 2'h0))
        else $error("wait entry disagrees with wait field");
    debug_clk_a: assert property (
        SYS_RESET_N [*2] |-> DEBUG_CLK_EN == $past(dbg_want))
        else $error("debug clock enable wrong");
    wdog_reset_a: assert property (WDOG_RESET |=> !SYS_RESET_N)
        else $error("watchdog request did not reset the chip");
    soft_reset_a: assert property (ctl_wr && PWDATA[4] |=> !SYS_RESET_N)
        else $error("soft reset trigger did not reset the chip");
endmodule

bind sgu_regs sgu_regs_asserts u_sgu_regs_asserts (.*);

// ---- test/tb_top.sv ----
// Self-checking bench for the system glue unit registers.
`timescale 1ns/1ns
module tb_top;
    typedef struct packed {
        logic w;
        logic [7:0] a;
        logic [15:0] d;
        logic [15:0] e;
        logic [1:0] lp;
    } sgu_row_t;
    localparam logic [15:0] IDU = sgu_pkg::ID_UPPER_VAL;
    localparam logic [15:0] IDL = sgu_pkg::ID_LOWER_VAL;
    // Write, address, data, expected read, expected stop and wait entry.
    localparam sgu_row_t ROWS [16] = '{
        '{1'b0,8'h00,16'h0,16'h0000,2'h3}, '{1'b0,8'h04,16'h0,16'h0004,2'h3},
        '{1'b1,8'h18,16'hffff,16'h0,2'h3}, '{1'b0,8'h18,16'h0,IDU,2'h3},
        '{1'b0,8'h1c,16'h0,IDL,2'h3}, '{1'b1,8'h08,16'ha5a5,16'h0,2'h3},
        '{1'b0,8'h08,16'h0,16'ha5a5,2'h3}, '{1'b1,8'h00,16'h0005,16'h0,2'h0},
        '{1'b0,8'h00,16'h0,16'h0005,2'h0}, '{1'b1,8'h00,16'h0000,16'h0,2'h3},
        '{1'b1,8'h00,16'hffee,16'h0,2'h0}, '{1'b1,8'h00,16'h0000,16'h0,2'h0},
        '{1'b0,8'h00,16'h0,16'h000e,2'h0}, '{1'b1,8'h04,16'h0004,16'h0,2'h0},
        '{1'b0,8'h04,16'h0,16'h0038,2'h0}, '{1'b1,8'h04,16'h003c,16'h0,2'h0}};
    logic mclk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pin_n = 1'b1, wdog = 1'b0, tap = 1'b0, go = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, sys_n, stop_req, wait_req, err;
    logic stop_en, wait_en, dbg_en, irq;
    sgu_row_t r;
    int err_total = 0;
    int total_checks = 0;

    always #25 mclk = ~mclk;

    sgu_core_model u_sgu_core_model (.clk(mclk), .go(go),
        .stop_req(stop_req), .wait_req(wait_req));
    sgu_regs u_sgu_regs (.MCLK(mclk), .RSTN(rstn), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .PIN_RESET_N(pin_n), .WDOG_RESET(wdog), .SYS_RESET_N(sys_n),
        .CORE_STOP_REQ(stop_req), .CORE_WAIT_REQ(wait_req),
        .CORE_TAP_EN(tap), .STOP_ENTER(stop_en), .WAIT_ENTER(wait_en),
        .DEBUG_CLK_EN(dbg_en), .IRQ(irq));

    task check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task pulse_core(input logic [1:0] exp);
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        @(posedge mclk);
        #1;
        check({30'h0, stop_en, wait_en}, {30'h0, exp});
    endtask

    task after_reset(input logic [15:0] st, input logic [15:0] sc);
        int n;
        n = 0;
        while (sys_n !== 1'b0 && n < 20) begin
            @(posedge mclk);
            n++;
        end
        while (sys_n !== 1'b1 && n < 400) begin
            @(posedge mclk);
            n++;
        end
        repeat (2) @(posedge mclk);
        apb(1'b0, 8'h04, 16'h0);
        check(rd, {16'h0, st});
        apb(1'b0, 8'h08, 16'h0);
        check(rd, {16'h0, sc});
        apb(1'b0, 8'h00, 16'h0);
        check(rd, 32'h0);
        $display("reset case done");
    endtask

    task final_report;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        repeat (3) @(posedge mclk);
        for (int i = 0; i < 16; i++) begin
            r = ROWS[i];
            tap <= i[0];
            apb(r.w, r.a, r.d);
            if (!r.w) check(rd, {16'h0, r.e});
            pulse_core(r.lp);
        end
        tap <= 1'b0;
        $display("table done");
        // Refused requests raised status bits 0 and 1; mask then clear.
        apb(1'b0, 8'h40, 16'h0);
        check(rd, 32'h3);
        check(irq, 1'b0);
        apb(1'b1, 8'h44, 16'h1);
        repeat (2) @(posedge mclk);
        check(irq, 1'b1);
        apb(1'b1, 8'h40, 16'h1);
        repeat (2) @(posedge mclk);
        check(irq, 1'b0);
        apb(1'b0, 8'h48, 16'h0);
        check(err, 1'b1);
        $display("interrupt and error case done");
        wdog <= 1'b1;
        @(posedge mclk);
        wdog <= 1'b0;
        after_reset(16'h0010, 16'ha5a5);
        apb(1'b1, 8'h00, 16'h0001);
        apb(1'b0, 8'h00, 16'h0);
        check(rd, 32'h1);
        pin_n <= 1'b0;
        repeat (3) @(posedge mclk);
        pin_n <= 1'b1;
        after_reset(16'h0018, 16'ha5a5);
        apb(1'b1, 8'h00, 16'h0010);
        after_reset(16'h0038, 16'ha5a5);
        rstn <= 1'b0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        after_reset(16'h0004, 16'h0000);
        final_report();
    end

    initial begin
        repeat (6000) @(posedge mclk);
        err_total++;
        final_report();
    end
endmodule
